// File: pkg/ipc_defines.svh
// offsets, field positions, reset values and counts of the input capture unit
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// register indices; byte address is four times the index
`define IPC_IDX_CSR      8'h56
`define IPC_IDX_TRIG1    8'h58
`define IPC_IDX_SRC1     8'h59
`define IPC_IDX_LSB1     8'h5A
`define IPC_IDX_MSB1     8'h5B
`define IPC_IDX_TRIG2    8'h5C
`define IPC_IDX_SRC2     8'h5D
`define IPC_IDX_LSB2     8'h5E
`define IPC_IDX_MSB2     8'h5F

// control/status field positions, c is the channel index 0 or 1
`define IPC_CSR_TEST     1:0
`define IPC_BIT_START(c) (5 + 2 * (c))
`define IPC_BIT_STOP(c)  (4 + 2 * (c))
`define IPC_BIT_ROLL(c)  (2 + (c))

// trigger field codes
`define IPC_MODE_OFF     2'h0
`define IPC_MODE_SS      2'h1
`define IPC_MODE_FREE    2'h2
`define IPC_MODE_RUS     2'h3
`define IPC_LAT_STOP     0
`define IPC_LAT_START    1
`define IPC_EDGE_RISE    0
`define IPC_EDGE_FALL    1
`define IPC_TEST_ON      2'h3

// reset values and counter limits
`define IPC_CSR_RST      8'h00
`define IPC_TRIG_RST     8'h00
`define IPC_SRC_RST      8'h00
`define IPC_CNT_MAX      16'hFFFF
`define IPC_CNT_ZERO     16'h0000

`endif

// File: pkg/ipc_pkg.sv
// types of the input capture unit
`default_nettype none
package ipc_pkg;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } ipc_wb_req_t;

  // counter run state of one channel
  typedef enum logic [2:0] {
    IPC_RUN_OFF  = 3'h1,
    IPC_RUN_ON   = 3'h2,
    IPC_RUN_HALT = 3'h4
  } ipc_run_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] latSel;
    logic [1:0] startEdge;
    logic [1:0] stopEdge;
  } ipc_trig_t;

  // pin index is {port, bit}: port C,D,F,G and bit 1,3,5,7
  typedef struct packed {
    logic [3:0] startPin;
    logic [3:0] stopPin;
  } ipc_src_t;

  typedef struct packed {
    ipc_trig_t   trig;
    ipc_src_t    src;
    ipc_run_t    run;
    logic [15:0] cnt;
    logic [15:0] lat;
    logic [7:0]  hold;
    logic        startFlg;
    logic        stopFlg;
    logic        rollFlg;
    logic        startEn;
    logic        stopEn;
  } ipc_chan_t;

  typedef struct packed {
    ipc_chan_t [1:0] ch;
    logic [1:0]      testMode;
    logic            ack;
    logic [7:0]      dat;
    logic            irq;
  } ipc_state_t;

  typedef struct packed {
    logic prev;
  } ipc_edge_t;

endpackage : ipc_pkg
`default_nettype wire

// File: core/ipc_edge_sel.sv
// pin selection and edge detection for one start or stop input
`timescale 1ns/10ps
`default_nettype none
`include "ipc_defines.svh"

module ipc_edge_sel (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // pins and selection
  input  wire logic [15:0] portPins,
  input  wire logic [3:0]  pinSel,
  input  wire logic [1:0]  edgeSel,
  // condition pulse
  output logic             cond
);

  ipc_pkg::ipc_edge_t st_r;
  ipc_pkg::ipc_edge_t st_nxt;
  logic               level;

  always_comb begin
    level      = portPins[pinSel];
    st_nxt     = st_r;
    st_nxt.prev = level;
    cond = (edgeSel[`IPC_EDGE_RISE] && level && !st_r.prev) ||
           (edgeSel[`IPC_EDGE_FALL] && !level && st_r.prev);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : ipc_edge_sel
`default_nettype wire

// File: core/ipc_capture.sv
// two-channel input capture unit with a classic wishbone register slave
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ipc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RL1: start-stop mode: Start runs, Stop halts counter
// RL2: one latch per channel, newer capture overwrites
// RL3: software clears counter before start-stop measurement
// RL4: free mode counts always; conditions only latch and set flags
// RL5: free mode conditions serve as interrupt sources
// RL6: run-until-stop counts from enable to Stop
// RL7: halted run-until-stop counter resumes only after software enable
// RL8: status bit 7/6: channel 2 Start/Stop
// RL9: status bit 5/4: channel 1 Start/Stop
// RL10: status bit 3/2: channel 2/1 rollover
// RL11: status read clears flags and interrupt, not enables
// RL12: write bits 7:4 set Start/Stop interrupt enables
// RL13: write bit 3 clears channel 2 counter
// RL14: write bit 2 clears channel 1 counter
// RL15: test code 11 counts bytes without carry
// RL16: 16-bit counter advanced by prescaler tap
// RL17: latch select: never, Stop, Start, either
// RL18: counter never auto-cleared, wraps setting rollover
// RL19: low byte read holds matching high byte
// RL20: interrupt while enabled flag set, cleared by read
module ipc_capture (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // wishbone slave
  input  wire ipc_pkg::ipc_wb_req_t wbReq,
  output logic                      wbAck,
  output logic [31:0]               wbDat,
  // measured signals and prescaler tap
  input  wire logic [15:0]          portPins,
  input  wire logic                 prescTick,
  // capture interrupt request
  output logic                      captureIrq
);

  ipc_pkg::ipc_state_t st_r;
  ipc_pkg::ipc_state_t st_nxt;
  logic [1:0]          startC;
  logic [1:0]          stopC;
  logic [1:0]          trigWr;
  logic [1:0]          srcWr;
  logic [1:0]          lsbRd;
  logic [1:0]          msbRd;
  logic [1:0]          cntGo;
  logic                req;
  logic                wrReq;
  logic                csrWr;
  logic                csrRd;

  function automatic logic hitIdx(input logic [31:0] adr, input logic [7:0] idx);
    return (adr[31:10] == 22'h0) && (adr[9:2] == idx);
  endfunction : hitIdx

  function automatic logic [7:0] statusByte(input ipc_pkg::ipc_state_t s);
    return {s.ch[1].startFlg, s.ch[1].stopFlg,                 // [RL8]
            s.ch[0].startFlg, s.ch[0].stopFlg,                 // [RL9]
            s.ch[1].rollFlg, s.ch[0].rollFlg, 2'h0};           // [RL10]
  endfunction : statusByte

  //////////////////////////////////////////////////////////////////////////////
  // bus decode: one access per request, answered on the next edge
  assign req   = wbReq.cyc && wbReq.stb && !st_r.ack;
  assign wrReq = req && wbReq.we && wbReq.sel[0];
  assign csrWr = wrReq && hitIdx(wbReq.adr, `IPC_IDX_CSR);
  assign csrRd = req && !wbReq.we && hitIdx(wbReq.adr, `IPC_IDX_CSR);

  //////////////////////////////////////////////////////////////////////////////
  // per-channel inputs, decode and count enable
  for (genvar g = 0; g < 2; g++) begin : g_chan
    ipc_edge_sel u_start (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .portPins (portPins),
      .pinSel   (st_r.ch[g].src.startPin),
      .edgeSel  (st_r.ch[g].trig.startEdge),
      .cond     (startC[g])
    );
    ipc_edge_sel u_stop (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .portPins (portPins),
      .pinSel   (st_r.ch[g].src.stopPin),
      .edgeSel  (st_r.ch[g].trig.stopEdge),
      .cond     (stopC[g])
    );

    assign trigWr[g] = wrReq &&
      hitIdx(wbReq.adr, (g == 0) ? `IPC_IDX_TRIG1 : `IPC_IDX_TRIG2);
    assign srcWr[g] = wrReq &&
      hitIdx(wbReq.adr, (g == 0) ? `IPC_IDX_SRC1 : `IPC_IDX_SRC2);
    assign lsbRd[g] = req && !wbReq.we &&
      hitIdx(wbReq.adr, (g == 0) ? `IPC_IDX_LSB1 : `IPC_IDX_LSB2);
    assign msbRd[g] = req && !wbReq.we &&
      hitIdx(wbReq.adr, (g == 0) ? `IPC_IDX_MSB1 : `IPC_IDX_MSB2);

    // the counter only moves on a prescaler tick
    assign cntGo[g] = prescTick &&                                         // [RL16]
      ((st_r.ch[g].trig.mode == `IPC_MODE_FREE) ||                         // [RL4]
       ((st_r.ch[g].run == ipc_pkg::IPC_RUN_ON) &&
        ((st_r.ch[g].trig.mode == `IPC_MODE_SS) ||
         (st_r.ch[g].trig.mode == `IPC_MODE_RUS))));
  end

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req;
    st_nxt.dat = 8'h00;
    if (csrWr) begin
      st_nxt.testMode = wbReq.dat[`IPC_CSR_TEST];
    end
    if (csrRd) begin
      st_nxt.dat = statusByte(st_r);
    end
    for (int i = 0; i < 2; i++) begin
      // run state
      case (st_r.ch[i].run)
        ipc_pkg::IPC_RUN_OFF,
        ipc_pkg::IPC_RUN_HALT: begin
          if ((st_r.ch[i].trig.mode == `IPC_MODE_SS) && startC[i]) begin
            st_nxt.ch[i].run = ipc_pkg::IPC_RUN_ON;                        // [RL1]
          end
        end
        ipc_pkg::IPC_RUN_ON: begin
          if (stopC[i]) begin
            st_nxt.ch[i].run = ipc_pkg::IPC_RUN_HALT;                      // [RL1] [RL6]
          end
        end
        default: begin
          st_nxt.ch[i].run = ipc_pkg::IPC_RUN_OFF;
        end
      endcase
      // a trigger write is the software enable of run-until-stop
      if (trigWr[i]) begin
        st_nxt.ch[i].trig = wbReq.dat[7:0];
        if (wbReq.dat[7:6] == `IPC_MODE_RUS) begin
          st_nxt.ch[i].run = ipc_pkg::IPC_RUN_ON;                          // [RL6] [RL7]
        end else begin
          st_nxt.ch[i].run = ipc_pkg::IPC_RUN_OFF;
        end
      end
      if (srcWr[i]) begin
        st_nxt.ch[i].src = wbReq.dat[7:0];
      end
      // counter
      if (cntGo[i]) begin
        if (st_r.testMode == `IPC_TEST_ON) begin
          st_nxt.ch[i].cnt = {st_r.ch[i].cnt[15:8] + 8'h01,
                              st_r.ch[i].cnt[7:0] + 8'h01};                // [RL15]
        end else begin
          st_nxt.ch[i].cnt = st_r.ch[i].cnt + 16'h0001;                    // [RL18]
        end
      end
      // count latch, a newer capture simply overwrites
      if ((st_r.ch[i].trig.latSel[`IPC_LAT_STOP] && stopC[i]) ||
          (st_r.ch[i].trig.latSel[`IPC_LAT_START] && startC[i])) begin
        st_nxt.ch[i].lat = st_r.ch[i].cnt;                                 // [RL2] [RL17]
      end
      // low byte read freezes the high byte against a later capture
      if (lsbRd[i]) begin
        st_nxt.ch[i].hold = st_r.ch[i].lat[15:8];                          // [RL19]
        st_nxt.dat        = st_r.ch[i].lat[7:0];
      end
      if (msbRd[i]) begin
        st_nxt.dat = st_r.ch[i].hold;                                      // [RL19]
      end
      // flags: clear on read, a same-cycle event wins
      if (csrRd) begin
        st_nxt.ch[i].startFlg = 1'b0;                                      // [RL11]
        st_nxt.ch[i].stopFlg  = 1'b0;
        st_nxt.ch[i].rollFlg  = 1'b0;
      end
      if (startC[i]) begin
        st_nxt.ch[i].startFlg = 1'b1;                                      // [RL5]
      end
      if (stopC[i]) begin
        st_nxt.ch[i].stopFlg = 1'b1;                                       // [RL5]
      end
      if (cntGo[i] && (st_r.ch[i].cnt == `IPC_CNT_MAX)) begin
        st_nxt.ch[i].rollFlg = 1'b1;                                       // [RL18]
      end
      // enables and counter clear; the counter is cleared nowhere else
      if (csrWr) begin
        st_nxt.ch[i].startEn = wbReq.dat[`IPC_BIT_START(i)];               // [RL12]
        st_nxt.ch[i].stopEn  = wbReq.dat[`IPC_BIT_STOP(i)];                // [RL12]
        if (wbReq.dat[`IPC_BIT_ROLL(i)]) begin
          st_nxt.ch[i].cnt     = `IPC_CNT_ZERO;                            // [RL13] [RL14]
          st_nxt.ch[i].rollFlg = 1'b0;                                     // [RL13] [RL14]
        end
      end
    end
    st_nxt.irq = (st_nxt.ch[0].startFlg && st_nxt.ch[0].startEn) ||       // [RL20]
                 (st_nxt.ch[0].stopFlg && st_nxt.ch[0].stopEn) ||
                 (st_nxt.ch[1].startFlg && st_nxt.ch[1].startEn) ||
                 (st_nxt.ch[1].stopFlg && st_nxt.ch[1].stopEn);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r                  <= '0;
      st_r.ch[0].run        <= ipc_pkg::IPC_RUN_OFF;
      st_r.ch[1].run        <= ipc_pkg::IPC_RUN_OFF;
      st_r.ch[0].trig       <= `IPC_TRIG_RST;
      st_r.ch[1].trig       <= `IPC_TRIG_RST;
      st_r.ch[0].src        <= `IPC_SRC_RST;
      st_r.ch[1].src        <= `IPC_SRC_RST;
      st_r.testMode         <= 2'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wbAck      = st_r.ack;
  assign wbDat      = {24'h000000, st_r.dat};
  assign captureIrq = st_r.irq;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_read_clears: assert property ( // [RL11]
    csrRd && (startC == 2'h0) && (stopC == 2'h0) && (cntGo == 2'h0)
    |=> (statusByte(st_r) == 8'h00) && !captureIrq
        && ($stable(st_r.ch[0].startEn)) && ($stable(st_r.ch[1].stopEn))
  ) else $error("status read did not clear flags");

  sequence s_csr_read;
    csrRd;
  endsequence

  a_status_map: assert property ( // [RL8] [RL9] [RL10]
    s_csr_read ##1 wbAck
    |-> wbDat[7:2] == {$past(st_r.ch[1].startFlg), $past(st_r.ch[1].stopFlg),
                       $past(st_r.ch[0].startFlg), $past(st_r.ch[0].stopFlg),
                       $past(st_r.ch[1].rollFlg), $past(st_r.ch[0].rollFlg)}
  ) else $error("status byte does not match flags");

  a_enable_write: assert property ( // [RL12]
    csrWr |=> st_r.ch[1].startEn == $past(wbReq.dat[7])
           && st_r.ch[1].stopEn == $past(wbReq.dat[6])
           && st_r.ch[0].startEn == $past(wbReq.dat[5])
           && st_r.ch[0].stopEn == $past(wbReq.dat[4])
  ) else $error("interrupt enables not written");

  a_irq_enabled: assert property ( // [RL20] [RL5]
    !csrRd && !csrWr && startC[0] && st_r.ch[0].startEn
    |=> captureIrq ##1 (captureIrq || $past(csrRd))
  ) else $error("enabled start did not raise interrupt");

  a_bus_answer: assert property (
    req |=> wbAck ##1 !wbAck
  ) else $error("wishbone answer not one cycle");

  a_irq_level: assert property ( // [RL20]
    captureIrq == ((st_r.ch[0].startFlg && st_r.ch[0].startEn) ||
                   (st_r.ch[0].stopFlg && st_r.ch[0].stopEn) ||
                   (st_r.ch[1].startFlg && st_r.ch[1].startEn) ||
                   (st_r.ch[1].stopFlg && st_r.ch[1].stopEn))
  ) else $error("interrupt does not follow enabled flags");

  for (genvar g = 0; g < 2; g++) begin : g_chk
    sequence s_rus_halted;
      st_r.ch[g].trig.mode == `IPC_MODE_RUS && st_r.ch[g].run == ipc_pkg::IPC_RUN_HALT;
    endsequence

    a_ss_halt: assert property ( // [RL1]
      st_r.ch[g].trig.mode == `IPC_MODE_SS && st_r.ch[g].run == ipc_pkg::IPC_RUN_ON
      && stopC[g] && !trigWr[g]
      |=> st_r.ch[g].run == ipc_pkg::IPC_RUN_HALT && !cntGo[g]
          ##1 (!cntGo[g] || $past(startC[g]) || $past(trigWr[g]))
    ) else $error("start-stop counter did not halt");

    a_ss_start: assert property ( // [RL1]
      st_r.ch[g].trig.mode == `IPC_MODE_SS && st_r.ch[g].run != ipc_pkg::IPC_RUN_ON
      && startC[g] && !trigWr[g]
      |=> st_r.ch[g].run == ipc_pkg::IPC_RUN_ON
    ) else $error("start-stop counter did not start");

    a_start_flag: assert property ( // [RL5]
      startC[g] |=> st_r.ch[g].startFlg
    ) else $error("start flag not set");

    a_stop_flag: assert property ( // [RL5]
      stopC[g] |=> st_r.ch[g].stopFlg
    ) else $error("stop flag not set");

    a_rus_enable: assert property ( // [RL6] [RL7]
      trigWr[g] && wbReq.dat[7:6] == `IPC_MODE_RUS
      |=> st_r.ch[g].run == ipc_pkg::IPC_RUN_ON
    ) else $error("run-until-stop not enabled by software");

    a_off_still: assert property ( // [RL1] [RL6]
      st_r.ch[g].trig.mode == `IPC_MODE_OFF |-> !cntGo[g]
    ) else $error("disabled counter moved");

    a_latch_takes: assert property ( // [RL2] [RL17]
      st_r.ch[g].trig.latSel == 2'h3 && (startC[g] || stopC[g])
      |=> st_r.ch[g].lat == $past(st_r.ch[g].cnt)
    ) else $error("count not latched");

    a_latch_never: assert property ( // [RL17]
      st_r.ch[g].trig.latSel == 2'h0 && !trigWr[g] |=> $stable(st_r.ch[g].lat)
    ) else $error("latch moved while disabled");

    a_free_counts: assert property ( // [RL4] [RL16]
      st_r.ch[g].trig.mode == `IPC_MODE_FREE && prescTick && !csrWr && !trigWr[g]
      && st_r.testMode != `IPC_TEST_ON
      |=> st_r.ch[g].cnt == $past(st_r.ch[g].cnt) + 16'h0001
    ) else $error("free counter did not advance");

    a_rus_stays: assert property ( // [RL7] [RL6]
      s_rus_halted ##0 (!trigWr[g] && !csrWr) [*3]
      |=> st_r.ch[g].run == ipc_pkg::IPC_RUN_HALT && !cntGo[g]
    ) else $error("halted counter resumed without enable");

    a_cnt_clear: assert property ( // [RL13] [RL14]
      csrWr && wbReq.dat[2 + g]
      |=> st_r.ch[g].cnt == `IPC_CNT_ZERO && !st_r.ch[g].rollFlg
    ) else $error("counter clear failed");

    a_wrap_flag: assert property ( // [RL18]
      cntGo[g] && st_r.ch[g].cnt == `IPC_CNT_MAX && !csrWr
      |=> st_r.ch[g].cnt == `IPC_CNT_ZERO && st_r.ch[g].rollFlg
    ) else $error("wrap did not set rollover");

    a_test_nocarry: assert property ( // [RL15]
      cntGo[g] && st_r.testMode == `IPC_TEST_ON && !csrWr && !trigWr[g]
      |=> st_r.ch[g].cnt[15:8] == $past(st_r.ch[g].cnt[15:8]) + 8'h01
       && st_r.ch[g].cnt[7:0] == $past(st_r.ch[g].cnt[7:0]) + 8'h01
    ) else $error("test mode carried between bytes");

    a_hold_copy: assert property ( // [RL19]
      lsbRd[g] |=> st_r.ch[g].hold == $past(st_r.ch[g].lat[15:8])
                   ##1 (msbRd[g] || lsbRd[g] || $stable(st_r.ch[g].hold))
    ) else $error("high byte not held");
  end

endmodule : ipc_capture
`default_nettype wire

// File: verif/ipc_pin_model.sv
// pin and prescaler tap model standing outside the input capture unit
`timescale 1ns/10ps
`default_nettype none

module ipc_pin_model #(
  parameter int TICK_DIV = 2
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // bench commands
  input  wire logic [15:0] pinReq,
  input  wire logic        tickEn,
  // pins and prescaler tap
  output var  logic [15:0] portPins,
  output var  logic        prescTick
);
  int phase;

  initial begin
    portPins  = 16'h0000;
    prescTick = 1'b0;
    phase     = 0;
  end

  // pins follow the bench one cycle later; one tap pulse per TICK_DIV enabled cycles
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      portPins  <= 16'h0000;
      prescTick <= 1'b0;
      phase     <= 0;
    end else begin
      portPins  <= pinReq;
      prescTick <= tickEn && (phase == TICK_DIV - 1);
      phase     <= (!tickEn || phase == TICK_DIV - 1) ? 0 : phase + 1;
    end
  end
endmodule : ipc_pin_model
`default_nettype wire

// File: verif/tb.sv
// self-checking testbench of the input capture unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb;
  localparam int          DIV     = 2;
  localparam logic [31:0] A_CSR   = 32'h0000_0158;
  localparam logic [31:0] A_TRIG1 = 32'h0000_0160;
  localparam logic [31:0] A_SRC1  = 32'h0000_0164;
  localparam logic [31:0] A_LSB1  = 32'h0000_0168;
  localparam logic [31:0] A_MSB1  = 32'h0000_016C;
  localparam logic [31:0] A_TRIG2 = 32'h0000_0170;
  localparam logic [31:0] A_SRC2  = 32'h0000_0174;
  localparam logic [31:0] A_LSB2  = 32'h0000_0178;
  localparam logic [31:0] A_MSB2  = 32'h0000_017C;

  typedef struct {
    logic [31:0] adr;
    logic        we;
    logic [7:0]  wd;
    logic [7:0]  exp;
  } ipc_row_t;

  logic                 ref_clk    = 1'b0;
  logic                 sys_rst    = 1'b1;
  ipc_pkg::ipc_wb_req_t wbReq      = '0;
  logic [15:0]          pinReq     = 16'h0000;
  logic                 tickEn     = 1'b0;
  logic                 wbAck;
  logic [31:0]          wbDat;
  logic [15:0]          portPins;
  logic                 prescTick;
  logic                 captureIrq;
  int                   fails      = 0;
  int                   compares   = 0;

  // write-only and unmapped places read as zero; flags read zero after reset
  ipc_row_t rows [7] = '{
    '{A_CSR,   1'b0, 8'h00, 8'h00},
    '{A_TRIG1, 1'b1, 8'h00, 8'h00},
    '{A_SRC1,  1'b1, 8'h00, 8'h00},
    '{A_TRIG2, 1'b1, 8'h00, 8'h00},
    '{A_SRC2,  1'b1, 8'h55, 8'h00},
    '{32'h0000_015C, 1'b1, 8'hFF, 8'h00},
    '{A_CSR,   1'b1, 8'hF0, 8'h00}
  };

  always #50 ref_clk = ~ref_clk;

  ipc_capture u_dut (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .wbReq      (wbReq),
    .wbAck      (wbAck),
    .wbDat      (wbDat),
    .portPins   (portPins),
    .prescTick  (prescTick),
    .captureIrq (captureIrq)
  );

  ipc_pin_model #(.TICK_DIV(DIV)) u_pins (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .pinReq    (pinReq),
    .tickEn    (tickEn),
    .portPins  (portPins),
    .prescTick (prescTick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic [31:0] adr, input logic we, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr, dat: {24'h000000, wd}};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDat[7:0];
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    if (wbAck !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask : wb

  task automatic wr(input logic [31:0] adr, input logic [7:0] d);
    logic [7:0] x;
    wb(adr, 1'b1, d, x);
  endtask : wr

  task automatic rdc(input logic [31:0] adr, input logic [7:0] exp);
    logic [7:0] x;
    wb(adr, 1'b0, 8'h00, x);
    `CHK(x, exp)
  endtask : rdc

  task automatic pin(input int idx, input logic val);
    @(posedge ref_clk);
    pinReq[idx] <= val;
    repeat (4) @(posedge ref_clk);
  endtask : pin

  // exactly n tap pulses, then let the counter settle
  task automatic ticks(input int n);
    @(posedge ref_clk);
    tickEn <= 1'b1;
    repeat (n * DIV) @(posedge ref_clk);
    tickEn <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : ticks

  task automatic irqc(input logic exp);
    @(negedge ref_clk);
    `CHK(captureIrq, exp)
  endtask : irqc

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wr(rows[i].adr, rows[i].wd);
      end
      rdc(rows[i].adr, rows[i].exp);
    end
    // start-stop on one pin, counter cleared first
    wr(A_CSR, 8'h34);
    wr(A_SRC1, 8'h00);
    wr(A_TRIG1, 8'h56);
    ticks(5);
    pin(0, 1'b1);
    ticks(7);
    pin(0, 1'b0);
    ticks(4);
    rdc(A_LSB1, 8'h07);
    rdc(A_MSB1, 8'h00);
    irqc(1'b1);
    rdc(A_CSR, 8'h30);
    irqc(1'b0);
    rdc(A_CSR, 8'h00);
    // free running, latch on either edge
    wr(A_CSR, 8'h34);
    wr(A_TRIG1, 8'hB6);
    ticks(3);
    pin(0, 1'b1);
    ticks(2);
    pin(0, 1'b0);
    rdc(A_LSB1, 8'h05);
    ticks(2);
    pin(0, 1'b1);
    rdc(A_LSB1, 8'h07);
    irqc(1'b1);
    rdc(A_CSR, 8'h30);
    // run until stop on channel 2
    wr(A_CSR, 8'hC8);
    wr(A_SRC2, 8'h55);
    wr(A_TRIG2, 8'hDF);
    ticks(6);
    pin(5, 1'b1);
    ticks(4);
    pin(5, 1'b0);
    rdc(A_LSB2, 8'h06);
    rdc(A_MSB2, 8'h00);
    rdc(A_CSR, 8'hC0);
    wr(A_TRIG2, 8'hDF);
    ticks(3);
    pin(5, 1'b1);
    rdc(A_LSB2, 8'h09);
    wr(A_CSR, 8'h08);
    wr(A_TRIG2, 8'hDF);
    ticks(1);
    pin(5, 1'b0);
    rdc(A_LSB2, 8'h01);
    // byte-wise test counting and rollover on channel 1
    wr(A_CSR, 8'h07);
    ticks(3);
    pin(0, 1'b0);
    rdc(A_LSB1, 8'h03);
    rdc(A_MSB1, 8'h03);
    ticks(253);
    rdc(A_CSR, 8'hD4);
    ticks(256);
    wr(A_CSR, 8'h04);
    rdc(A_CSR, 8'h00);
    ticks(2);
    pin(0, 1'b1);
    rdc(A_LSB1, 8'h02);
    rdc(A_MSB1, 8'h00);
    // start-stop with falling Start, rising Stop, latch on Start only
    wr(A_TRIG1, 8'h69);
    pin(0, 1'b0);
    irqc(1'b0);
    ticks(4);
    pin(0, 1'b1);
    ticks(2);
    rdc(A_LSB1, 8'h02);
    pin(0, 1'b0);
    rdc(A_LSB1, 8'h06);
    // reset in mid-run
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(A_LSB1, 8'h00);
    rdc(A_CSR, 8'h00);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
